// file: src/sgc_global_ctrl.sv
/*
 * Global control registers 0x05..0x07 with the per-port storm limiter they steer.
 * Assumes inputs synchronous to clk_sys; one blk_vld pulse per 64-byte block received.
 */
//
// Overview of operation
// - vlan enable bit puts forwarding into tag-based vlan mode; resets to zero
// - snoop bit sends every igmp packet to the processor on the cpu port
// - sniff mode one needs both ports matching; zero needs either
// - back pressure bit enables half-duplex back pressure on the cpu media interface
// - duplex bit one selects half duplex, zero full duplex; resets to zero
// - flow control bit enables full-duplex flow control on cpu media interface
// - null vid bit replaces a null tag vid with the receiving port vid
// - storm limit is 11 bits of 64-byte blocks, split over two registers
// - the limit is measured over 50 ms at 100 megabit, 500 ms at 10
// - storm limit resets to 0x4A with upper bits zero
// - multicast exclusion limits only broadcast frames, else multicast counts too
`timescale 1ns/100ps
module sgc_global_ctrl #(
	parameter int unsigned NPORT     = 5,
	parameter int unsigned P100_CYC  = sgc_pkg::PERIOD_100_CYC,
	parameter int unsigned P10_CYC   = sgc_pkg::PERIOD_10_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire logic              ce,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	input  wire logic [7:0]        addr,
	input  wire logic [7:0]        wr_data,
	output logic      [7:0]        rd_data,
	input  wire logic              mcast_excl,
	input  wire logic [NPORT-1:0]  blk_vld,
	input  wire logic [NPORT-1:0]  blk_bcast,
	input  wire logic [NPORT-1:0]  blk_mcast,
	input  wire logic [NPORT-1:0]  port_spd10,
	output sgc_pkg::sgc_ctrl_s     ctrl,
	output logic      [NPORT-1:0]  storm_drop
);
	import sgc_pkg::*;

	if (NPORT < 1 || P100_CYC < 2 || P10_CYC < 2) begin : g_bad_param
		$error("sgc_global_ctrl: unsupported parameter values");
	end

	sgc_ctrl_s                  ctrl_reg, ctrl_next;
	logic [7:0]                 rd_reg, rd_next;
	logic [31:0]                t100_reg, t100_next, t10_reg, t10_next;
	logic [LIMIT_W-1:0]         cnt_reg [NPORT], cnt_next [NPORT];
	logic [NPORT-1:0]           drop_reg, drop_next;
	logic                       tick100, tick10;
	logic [NPORT-1:0]           storm_cls;
	logic [LIMIT_W-1:0]         base;

	function automatic logic wr_hit(input logic [7:0] off);
		return wr_en && ce && (addr == off);
	endfunction : wr_hit

	assign tick100 = (t100_reg == P100_CYC - 1);
	assign tick10  = (t10_reg == P10_CYC - 1);

	always_comb begin
		ctrl_next = ctrl_reg;
		rd_next   = rd_reg;
		t100_next = t100_reg;
		t10_next  = t10_reg;
		drop_next = drop_reg;
		storm_cls = '0;
		base      = '0;
		for (int p = 0; p < NPORT; p++) begin
			cnt_next[p] = cnt_reg[p];
		end
		if (ce) begin
			if (wr_hit(OFF_VLAN_SNOOP)) begin
				ctrl_next.vlan_en    = wr_data[BIT_VLAN_EN];
				ctrl_next.igmp_snoop = wr_data[BIT_IGMP_SNOOP];
				ctrl_next.sniff_both = wr_data[BIT_SNIFF_BOTH];
			end
			if (wr_hit(OFF_P5_STORM_HI)) begin
				ctrl_next.p5_bp_en           = wr_data[BIT_P5_BP];
				ctrl_next.p5_half            = wr_data[BIT_P5_HALF];
				ctrl_next.p5_fc_en           = wr_data[BIT_P5_FC];
				ctrl_next.p5_spd10           = wr_data[BIT_P5_SPD10];
				ctrl_next.null_vid_repl      = wr_data[BIT_NULL_VID];
				ctrl_next.storm_limit[10:8]  = wr_data[2:0];
			end
			if (wr_hit(OFF_STORM_LO)) begin
				ctrl_next.storm_limit[7:0] = wr_data;
			end
			if (rd_en) begin
				case (addr)
					OFF_VLAN_SNOOP:  rd_next = {ctrl_reg.vlan_en, ctrl_reg.igmp_snoop,
						5'h00, ctrl_reg.sniff_both};
					OFF_P5_STORM_HI: rd_next = {ctrl_reg.p5_bp_en, ctrl_reg.p5_half,
						ctrl_reg.p5_fc_en, ctrl_reg.p5_spd10, ctrl_reg.null_vid_repl,
						ctrl_reg.storm_limit[10:8]};
					OFF_STORM_LO:    rd_next = ctrl_reg.storm_limit[7:0];
					default:         rd_next = 8'h00;
				endcase
			end
			t100_next = tick100 ? 32'h0000_0000 : t100_reg + 32'h0000_0001;
			t10_next  = tick10 ? 32'h0000_0000 : t10_reg + 32'h0000_0001;
			for (int p = 0; p < NPORT; p++) begin
				storm_cls[p] = blk_vld[p] && (blk_bcast[p] || (blk_mcast[p] && !mcast_excl));
				base = (port_spd10[p] ? tick10 : tick100) ? '0 : cnt_reg[p];
				drop_next[p] = 1'b0;
				cnt_next[p]  = base;
				if (storm_cls[p]) begin
					if (base < ctrl_reg.storm_limit) begin
						cnt_next[p] = base + 11'h001;
					end else begin
						drop_next[p] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RST;
			rd_reg   <= 8'h00;
			t100_reg <= 32'h0000_0000;
			t10_reg  <= 32'h0000_0000;
			drop_reg <= '0;
			for (int p = 0; p < NPORT; p++) begin
				cnt_reg[p] <= '0;
			end
		end else begin
			ctrl_reg <= ctrl_next;
			rd_reg   <= rd_next;
			t100_reg <= t100_next;
			t10_reg  <= t10_next;
			drop_reg <= drop_next;
			for (int p = 0; p < NPORT; p++) begin
				cnt_reg[p] <= cnt_next[p];
			end
		end
	end

	assign ctrl       = ctrl_reg;
	assign rd_data    = rd_reg;
	assign storm_drop = drop_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_wr3;
		wr_hit(OFF_VLAN_SNOOP);
	endsequence
	sequence s_wr4;
		wr_hit(OFF_P5_STORM_HI);
	endsequence

	property p_vlan_snoop_sniff;
		s_wr3 |=> ctrl.vlan_en == $past(wr_data[7]) && ctrl.igmp_snoop == $past(wr_data[6])
			&& ctrl.sniff_both == $past(wr_data[0]);
	endproperty
	a_vlan_snoop_sniff: assert property (p_vlan_snoop_sniff) else $error("reg 0x05 write lost");
	property p_igmp_hold;
		!wr_hit(OFF_VLAN_SNOOP) |=> $stable(ctrl.igmp_snoop);
	endproperty
	a_igmp_hold: assert property (p_igmp_hold) else $error("snoop bit changed without write");
	property p_p5_link;
		s_wr4 |=> ctrl.p5_bp_en == $past(wr_data[7]) && ctrl.p5_half == $past(wr_data[6])
			&& ctrl.p5_fc_en == $past(wr_data[5]) && ctrl.p5_spd10 == $past(wr_data[4]);
	endproperty
	a_p5_link: assert property (p_p5_link) else $error("reg 0x06 link bits wrong");
	property p_nvid;
		s_wr4 |=> ctrl.null_vid_repl == $past(wr_data[3]);
	endproperty
	a_nvid: assert property (p_nvid) else $error("null vid bit wrong");
	property p_limit;
		wr_hit(OFF_STORM_LO) |=> ctrl.storm_limit == {$past(ctrl.storm_limit[10:8]),
			$past(wr_data)};
	endproperty
	a_limit: assert property (p_limit) else $error("storm limit write wrong");
	property p_limit_hi;
		s_wr4 |=> ctrl.storm_limit == {$past(wr_data[2:0]), $past(ctrl.storm_limit[7:0])};
	endproperty
	a_limit_hi: assert property (p_limit_hi) else $error("storm limit high bits wrong");
	property p_ctrl_stable;
		!wr_en |=> $stable(ctrl);
	endproperty
	a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed without write");
	property p_rsv_read;
		rd_en && ce && addr == OFF_VLAN_SNOOP |=> rd_data[5:1] == 5'h00
			&& rd_data[7] == $past(ctrl.vlan_en)
			&& rd_data[6] == $past(ctrl.igmp_snoop);
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reg 0x05 readback wrong");
	property p_drop;
		ce && storm_cls[0] && !tick100 && !tick10 && cnt_reg[0] >= ctrl.storm_limit
			|=> storm_drop[0];
	endproperty
	a_drop: assert property (p_drop) else $error("over-limit block not dropped");
	property p_pass;
		ce && blk_vld[0] && blk_mcast[0] && !blk_bcast[0] && mcast_excl |=> !storm_drop[0];
	endproperty
	a_pass: assert property (p_pass) else $error("excluded multicast dropped");
	property p_period;
		ce && tick100 |=> t100_reg == 32'h0000_0000;
	endproperty
	a_period: assert property (p_period) else $error("period timer not restarted");
	property p_sniff;
		s_wr3 ##1 !wr_en |=> ctrl.sniff_both == $past(wr_data[0], 2);
	endproperty
	a_sniff: assert property (p_sniff) else $error("sniff mode not held");
	property p_keep;
		ce && storm_cls[0] && !tick100 && !tick10 && cnt_reg[0] < ctrl.storm_limit
			|=> !storm_drop[0] && cnt_reg[0] == $past(cnt_reg[0]) + 11'h001;
	endproperty
	a_keep: assert property (p_keep) else $error("block under limit not counted");
	property p_period10;
		ce && tick10 |=> t10_reg == 32'h0000_0000;
	endproperty
	a_period10: assert property (p_period10) else $error("slow period not restarted");
	property p_ce_freeze;
		!ce |=> $stable(ctrl) && $stable(rd_data) && $stable(storm_drop) && $stable(t100_reg);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");
endmodule : sgc_global_ctrl

// file: src/sgc_pkg.sv
/*
 * Constants, field layout and carrier types for the global switch control block
 * at offsets 0x05..0x07.
 * Assumes an 8-bit management register port and a 250 MHz core clock.
 */
package sgc_pkg;
	localparam int unsigned          CLK_MHZ         = 250;
	localparam logic [7:0]           OFF_VLAN_SNOOP  = 8'h05;
	localparam logic [7:0]           OFF_P5_STORM_HI = 8'h06;
	localparam logic [7:0]           OFF_STORM_LO    = 8'h07;
	localparam int unsigned          BIT_VLAN_EN     = 7;
	localparam int unsigned          BIT_IGMP_SNOOP  = 6;
	localparam int unsigned          BIT_SNIFF_BOTH  = 0;
	localparam int unsigned          BIT_P5_BP       = 7;
	localparam int unsigned          BIT_P5_HALF     = 6;
	localparam int unsigned          BIT_P5_FC       = 5;
	localparam int unsigned          BIT_P5_SPD10    = 4;
	localparam int unsigned          BIT_NULL_VID    = 3;
	localparam int unsigned          LIMIT_W         = 11;
	localparam logic [10:0]          LIMIT_RST       = 11'h04A;
	localparam int unsigned          PERIOD_100_MS   = 50;
	localparam int unsigned          PERIOD_10_MS    = 500;
	localparam int unsigned          PERIOD_100_CYC  = PERIOD_100_MS * CLK_MHZ * 1000;
	localparam int unsigned          PERIOD_10_CYC   = PERIOD_10_MS * CLK_MHZ * 1000;

	typedef struct packed {
		logic        vlan_en;
		logic        igmp_snoop;
		logic        sniff_both;
		logic        p5_bp_en;
		logic        p5_half;
		logic        p5_fc_en;
		logic        p5_spd10;
		logic        null_vid_repl;
		logic [10:0] storm_limit;
	} sgc_ctrl_s;

	localparam sgc_ctrl_s CTRL_RST = '{vlan_en: 1'b0, igmp_snoop: 1'b0, sniff_both: 1'b0,
		p5_bp_en: 1'b0, p5_half: 1'b0, p5_fc_en: 1'b0, p5_spd10: 1'b0,
		null_vid_repl: 1'b0, storm_limit: LIMIT_RST};
endpackage : sgc_pkg

// file: tb/tb.sv
/*
 * Self-checking bench for sgc_global_ctrl: register map, reset values, storm limiter.
 * Assumes the storm periods are shortened to 20 and 200 cycles in this bench.
 */
`timescale 1ns/100ps
`define CHK(nm, x, g) begin checked++; if ((g) !== (x)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, x, g); end end
module tb;
	import sgc_pkg::*;
	logic       clk_sys, arst_n, ce, wr_en, rd_en, mcast_excl;
	logic [7:0] addr, wr_data, rd_data;
	logic [4:0] blk_vld, blk_bcast, blk_mcast, port_spd10, storm_drop;
	sgc_ctrl_s  ctrl, exp_c;
	int         fail_count, checked;
	logic [3:0] cases [4] = '{4'b1101, 4'b1010, 4'b0011, 4'b0000};

	sgc_global_ctrl #(.NPORT(5), .P100_CYC(20), .P10_CYC(200)) sgc_global_ctrl_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wr_data), .rd_data(rd_data), .mcast_excl(mcast_excl),
		.blk_vld(blk_vld), .blk_bcast(blk_bcast), .blk_mcast(blk_mcast),
		.port_spd10(port_spd10), .ctrl(ctrl), .storm_drop(storm_drop));

	task automatic report_and_stop;
		if (fail_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) begin wr_en <= 1'b1; addr <= a; wr_data <= d; end
		@(posedge clk_sys) wr_en <= 1'b0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_sys) begin rd_en <= 1'b1; addr <= a; end
		@(posedge clk_sys) rd_en <= 1'b0;
		@(negedge clk_sys) `CHK("rd_data", x, rd_data)
	endtask : rd

	// one block on port p: c = {mcast_excl, bcast, mcast, expected drop}
	task automatic blk_one(input int p, input logic [3:0] c);
		@(posedge clk_sys) begin
			mcast_excl <= c[3]; blk_vld[p] <= 1'b1; blk_bcast[p] <= c[2]; blk_mcast[p] <= c[1];
		end
		@(posedge clk_sys) blk_vld[p] <= 1'b0;
		@(negedge clk_sys) `CHK("storm_drop", c[0], storm_drop[p])
	endtask : blk_one

	// back-to-back broadcast blocks, limit 2; a pass after drops marks a new period
	task automatic storm_run(input int p, input int per);
		int n;
		logic prev;
		n = -1;
		prev = 1'b0;
		@(posedge clk_sys) begin blk_vld[p] <= 1'b1; blk_bcast[p] <= 1'b1; end
		for (int k = 0; k < 4 * per; k++) begin
			@(posedge clk_sys);
			@(negedge clk_sys);
			if (n >= 0) n++;
			else if (prev === 1'b1 && storm_drop[p] === 1'b0) n = 0;
			if (n >= 0) `CHK("storm_drop", ((n % per) >= 2), storm_drop[p])
			prev = storm_drop[p];
		end
		`CHK("storm_period_seen", 1'b1, (n >= 0))
		@(posedge clk_sys) begin blk_vld[p] <= 1'b0; blk_bcast[p] <= 1'b0; end
	endtask : storm_run

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end

	initial begin
		arst_n = 1'b0; ce = 1'b1; wr_en = 1'b0; rd_en = 1'b0; mcast_excl = 1'b0;
		addr = 8'h00; wr_data = 8'h00; blk_vld = 5'h00; blk_bcast = 5'h00;
		blk_mcast = 5'h00; port_spd10 = 5'h02; fail_count = 0; checked = 0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(negedge clk_sys) `CHK("ctrl", CTRL_RST, ctrl)
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h4A);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'hC1);
		for (int i = 0; i < 3; i++) begin
			wr(8'h05, (i == 2) ? 8'h01 : (8'h80 >> i));
			`CHK("ctrl_05", 3'h4 >> i, {ctrl.vlan_en, ctrl.igmp_snoop, ctrl.sniff_both})
		end
		for (int i = 3; i < 8; i++) begin
			wr(8'h06, 8'h01 << i);
			`CHK("ctrl_06", 5'h01 << (i - 3), {ctrl.p5_bp_en, ctrl.p5_half, ctrl.p5_fc_en,
				ctrl.p5_spd10, ctrl.null_vid_repl})
		end
		wr(8'h05, 8'hC1);
		wr(8'h06, 8'hFF);
		wr(8'h07, 8'h10);
		exp_c = {8'hFF, 11'h710};
		`CHK("ctrl", exp_c, ctrl)
		rd(8'h06, 8'hFF);
		wr(8'h08, 8'h55);
		rd(8'h08, 8'h00);
		@(posedge clk_sys) begin ce <= 1'b0; wr_en <= 1'b1; addr <= 8'h07; wr_data <= 8'h33; end
		@(posedge clk_sys) begin ce <= 1'b1; wr_en <= 1'b0; end
		rd(8'h07, 8'h10);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h00);
		for (int i = 0; i < 4; i++) blk_one(2, cases[i]);
		blk_one(0, 4'b1010);
		wr(8'h07, 8'h02);
		storm_run(0, 20);
		storm_run(1, 200);
		report_and_stop();
	end
endmodule : tb
